// *** rtl/irqfe_pkg.sv ***
/*
  Package for the interrupt flag and enable bank: register byte offsets,
  source indices, edge-select codes, reset values and the state carriers.
  Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
package irqfe_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_EDGE_SEL = 8'h00;
  localparam logic [7:0] OFS_CTRL_ZERO = 8'h04;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;
  localparam logic [7:0] OFS_CTRL_THREE = 8'h10;

  // Number of request sources
  localparam int NUM_SRC = 15;

  // Source indices; a lower index wins when several are pending and enabled
  localparam logic [3:0] SRC_PIN = 4'h0;
  localparam logic [3:0] SRC_TOUCH = 4'h1;
  localparam logic [3:0] SRC_TICK0 = 4'h2;
  localparam logic [3:0] SRC_T0_CMP_P = 4'h3;
  localparam logic [3:0] SRC_T0_CMP_A = 4'h4;
  localparam logic [3:0] SRC_T1_CMP_P = 4'h5;
  localparam logic [3:0] SRC_T1_CMP_A = 4'h6;
  localparam logic [3:0] SRC_TICK1 = 4'h7;
  localparam logic [3:0] SRC_SERIAL_IF = 4'h8;
  localparam logic [3:0] SRC_NVM = 4'h9;
  localparam logic [3:0] SRC_ASYNC_SERIAL = 4'ha;
  localparam logic [3:0] SRC_LOW_VOLT = 4'hb;
  localparam logic [3:0] SRC_CONV = 4'hc;
  localparam logic [3:0] SRC_T2_CMP_P = 4'hd;
  localparam logic [3:0] SRC_T2_CMP_A = 4'he;

  // Field positions in the first control register
  localparam int CTRL0_EMI_POS = 0;
  localparam int CTRL0_UNUSED_POS = 7;

  // Edge-select codes of the external pin
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Reset values
  localparam logic [1:0] EDGE_SEL_RST = 2'h0;
  localparam logic [14:0] SRC_BITS_RST = 15'h0000;
  localparam logic EMI_RST = 1'b0;

  // APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } irqfe_apb_req_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [1:0] edge_sel;
    logic global_irq_en;
    logic [14:0] en;
    logic [14:0] flag;
    logic pready;
    logic slverr;
    logic [31:0] rdata;
    logic irq;
    logic [3:0] src;
    logic wake;
  } irqfe_state_t;

  // Whole state of the pin edge detector
  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic pulse;
  } irqfe_edge_state_t;

endpackage

// *** rtl/irqfe_pin_edge.sv ***
/*
  External interrupt pin: three-stage synchroniser, agreement filter and
  edge detector steered by the two-bit edge select.
  Assumes the pin is asynchronous to SYS_CLK; output is a one-cycle pulse.
*/
`timescale 1ns/1ps
module irqfe_pin_edge (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  output logic edge_pulse
);

  irqfe_pkg::irqfe_edge_state_t st_q; // Registered state
  irqfe_pkg::irqfe_edge_state_t st_d; // Next state
  logic rise; // Agreed level went up
  logic fall; // Agreed level went down

  // Stage 0 feeds stage 1 only; stages 1 and 2 must agree before a change counts
  always_comb begin
    st_d = st_q;
    rise = 1'b0;
    fall = 1'b0;
    st_d.sync = {st_q.sync[1:0], pin};
    st_d.pulse = 1'b0;
    if (st_q.sync[1] == st_q.sync[2]) begin
      // Stable sample: compare with the last agreed level
      rise = st_q.sync[2] & ~st_q.lvl;
      fall = ~st_q.sync[2] & st_q.lvl;
      st_d.lvl = st_q.sync[2];
    end
    case (edge_sel)
      irqfe_pkg::EDGE_OFF: st_d.pulse = 1'b0;
      irqfe_pkg::EDGE_RISE: st_d.pulse = rise;
      irqfe_pkg::EDGE_FALL: st_d.pulse = fall;
      irqfe_pkg::EDGE_BOTH: st_d.pulse = rise | fall;
      default: st_d.pulse = 1'b0;
    endcase
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign edge_pulse = st_q.pulse;

  // With the pin disabled no pulse may ever leave
  AST_EDGE_OFF: assert property (@(posedge clk) disable iff (!rstn)
    (ce && edge_sel == irqfe_pkg::EDGE_OFF) |=> !edge_pulse)
    else $error("pin pulse with edge select off");

endmodule // irqfe_pin_edge

// *** rtl/irqfe_bank.sv ***
/*
  Interrupt request flag and enable bank with an APB register slave,
  external pin edge trigger, global enable, pending request, priority
  index and wake request toward the core.
  Assumes source events and the core acknowledge are one-cycle pulses
  on SYS_CLK; the pin is asynchronous.
*/
`timescale 1ns/1ps
module irqfe_bank (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INT_PIN,
  input wire logic [13:0] SRC_EVT,
  input wire logic IRQ_ACK,
  input wire logic [3:0] IRQ_ACK_SRC,
  output logic IRQ_REQ,
  output logic [3:0] IRQ_SRC,
  output logic WAKE_REQ
);

  irqfe_pkg::irqfe_apb_req_t req; // Bus request bundle
  irqfe_pkg::irqfe_state_t st_q; // Registered state
  irqfe_pkg::irqfe_state_t st_d; // Next state
  logic pin_edge; // Qualified pin edge pulse
  logic [14:0] evt_all; // All source events, pin in slot zero
  logic [14:0] wr_mask; // Flags written this cycle
  logic [14:0] wr_val; // Value written to those flags
  logic [14:0] ack_hit; // Flag selected by the core acknowledge
  logic [14:0] flag_nx; // Next flag values
  logic [14:0] live; // Pending and enabled
  logic [31:0] rd_mux; // Read data for the current address
  logic hit; // Address maps to a register
  logic commit; // Access phase completes this edge
  logic wr_commit; // Completing write to a mapped register

  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};

  // Pin trigger path; the synchroniser lives in the leaf
  irqfe_pin_edge u_pin (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .ce(CE),
    .pin(INT_PIN),
    .edge_sel(st_q.edge_sel),
    .edge_pulse(pin_edge)
  );

  assign evt_all = {SRC_EVT, pin_edge};
  assign commit = req.sel & req.enable & st_q.pready;
  assign wr_commit = commit & req.write & hit;
  assign live = st_q.flag & st_q.en;

  // Address decode and read mux; layouts are regular so slices suffice
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (req.addr)
      irqfe_pkg::OFS_EDGE_SEL: begin
        rd_mux = {30'h0000_0000, st_q.edge_sel};
      end
      irqfe_pkg::OFS_CTRL_ZERO: begin
        rd_mux = {24'h00_0000, 1'b0, st_q.flag[2:0], st_q.en[2:0], st_q.global_irq_en};
      end
      irqfe_pkg::OFS_CTRL_ONE: begin
        rd_mux = {24'h00_0000, st_q.flag[6:3], st_q.en[6:3]};
      end
      irqfe_pkg::OFS_CTRL_TWO: begin
        rd_mux = {24'h00_0000, st_q.flag[10:7], st_q.en[10:7]};
      end
      irqfe_pkg::OFS_CTRL_THREE: begin
        rd_mux = {24'h00_0000, st_q.flag[14:11], st_q.en[14:11]};
      end
      default: begin
        // Unmapped: zero data and an error answer
        hit = 1'b0;
      end
    endcase
  end

  // Which flags a completing write touches, and with what
  always_comb begin
    wr_mask = 15'h0000;
    wr_val = 15'h0000;
    if (wr_commit) begin
      case (req.addr)
        irqfe_pkg::OFS_CTRL_ZERO: begin
          wr_mask[2:0] = 3'h7;
          wr_val[2:0] = req.wdata[6:4];
        end
        irqfe_pkg::OFS_CTRL_ONE: begin
          wr_mask[6:3] = 4'hf;
          wr_val[6:3] = req.wdata[7:4];
        end
        irqfe_pkg::OFS_CTRL_TWO: begin
          wr_mask[10:7] = 4'hf;
          wr_val[10:7] = req.wdata[7:4];
        end
        irqfe_pkg::OFS_CTRL_THREE: begin
          wr_mask[14:11] = 4'hf;
          wr_val[14:11] = req.wdata[7:4];
        end
        default: begin
          wr_mask = 15'h0000;
        end
      endcase
    end
  end

  // Per-source flag: software value, then acknowledge clear, then event set
  // The event is applied last so a pulse landing on a clear is never lost
  genvar gi;
  for (gi = 0; gi < irqfe_pkg::NUM_SRC; gi++) begin : g_src
    logic base; // Flag value before clears and sets
    assign ack_hit[gi] = IRQ_ACK & (IRQ_ACK_SRC == 4'(gi));
    assign base = wr_mask[gi] ? wr_val[gi] : st_q.flag[gi];
    assign flag_nx[gi] = evt_all[gi] | (base & ~ack_hit[gi]);
  end

  // Next state of the whole bank
  always_comb begin
    st_d = st_q;
    st_d.flag = flag_nx;
    // Enables change only by software writes; the global enable also clears on acknowledge
    if (wr_commit) begin
      case (req.addr)
        irqfe_pkg::OFS_EDGE_SEL: begin
          st_d.edge_sel = req.wdata[1:0];
        end
        irqfe_pkg::OFS_CTRL_ZERO: begin
          st_d.en[2:0] = req.wdata[3:1];
          st_d.global_irq_en = req.wdata[irqfe_pkg::CTRL0_EMI_POS];
        end
        irqfe_pkg::OFS_CTRL_ONE: begin
          st_d.en[6:3] = req.wdata[3:0];
        end
        irqfe_pkg::OFS_CTRL_TWO: begin
          st_d.en[10:7] = req.wdata[3:0];
        end
        irqfe_pkg::OFS_CTRL_THREE: begin
          st_d.en[14:11] = req.wdata[3:0];
        end
        default: begin
          st_d.global_irq_en = st_q.global_irq_en;
        end
      endcase
    end
    // Service entry blocks nesting; this beats a same-cycle software set
    if (IRQ_ACK) begin
      st_d.global_irq_en = 1'b0;
    end
    // One wait state: ready rises on the first access cycle, then drops
    if (req.sel && req.enable && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.rdata = rd_mux;
      st_d.slverr = ~hit;
    end else begin
      st_d.pready = 1'b0;
      st_d.slverr = 1'b0;
    end
    // Combined request, evaluated every cycle
    st_d.irq = st_q.global_irq_en & (|live);
    // Lowest index that is pending and enabled
    st_d.src = 4'h0;
    for (int k = irqfe_pkg::NUM_SRC - 1; k >= 0; k--) begin
      if (live[k]) begin
        st_d.src = 4'(k);
      end
    end
    // Wake-up ignores every enable on purpose
    st_d.wake = |st_q.flag;
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_q <= '0;
      st_q.edge_sel <= irqfe_pkg::EDGE_SEL_RST;
      st_q.en <= irqfe_pkg::SRC_BITS_RST;
      st_q.flag <= irqfe_pkg::SRC_BITS_RST;
      st_q.global_irq_en <= irqfe_pkg::EMI_RST;
    end else if (CE) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state registers
  assign PRDATA = st_q.rdata;
  assign PREADY = st_q.pready;
  assign PSLVERR = st_q.slverr;
  assign IRQ_REQ = st_q.irq;
  assign IRQ_SRC = st_q.src;
  assign WAKE_REQ = st_q.wake;

  // Helper: a read of the given register completes on this edge
  logic rd_edge_done;
  logic rd_ctrl0_done;
  assign rd_edge_done = commit && !req.write && req.addr == irqfe_pkg::OFS_EDGE_SEL;
  assign rd_ctrl0_done = commit && !req.write && req.addr == irqfe_pkg::OFS_CTRL_ZERO;

  AST_EDGE_UPPER_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    rd_edge_done |-> (PRDATA[31:2] == 30'h0000_0000))
    else $error("edge select upper bits not zero");

  AST_CTRL0_TOP_ZERO: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    rd_ctrl0_done |-> (!PRDATA[irqfe_pkg::CTRL0_UNUSED_POS] && PRDATA[0] == $past(st_q.global_irq_en)))
    else $error("control zero layout wrong");

  AST_EVENT_SETS: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && evt_all != 15'h0000) |=> ((st_q.flag & $past(evt_all)) == $past(evt_all)))
    else $error("event did not set its flag");

  AST_GLOBAL_GATES: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && !st_q.global_irq_en) |=> !IRQ_REQ)
    else $error("request with global enable clear");

  AST_REQ_RAISED: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && st_q.global_irq_en && live != 15'h0000) |=> IRQ_REQ)
    else $error("enabled pending flag gave no request");

  AST_ACK_BLOCKS: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && IRQ_ACK) |=> (!st_q.global_irq_en ##1 (!IRQ_REQ || !$past(CE))))
    else $error("service did not clear global enable");

  AST_WAKE_ON_FLAG: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && st_q.flag != 15'h0000) |=> WAKE_REQ)
    else $error("set flag gave no wake request");

  AST_TICK0_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && wr_commit && req.addr == irqfe_pkg::OFS_CTRL_ZERO && req.wdata[6]
      && !ack_hit[irqfe_pkg::SRC_TICK0])
      |=> st_q.flag[irqfe_pkg::SRC_TICK0])
    else $error("tick 0 flag not written");

  AST_T0_ENABLES: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && wr_commit && req.addr == irqfe_pkg::OFS_CTRL_ONE)
      |=> (st_q.en[irqfe_pkg::SRC_T0_CMP_A] == $past(req.wdata[1])
        && st_q.en[irqfe_pkg::SRC_T0_CMP_P] == $past(req.wdata[0])))
    else $error("timer 0 enables not written");

  AST_ONE_WAIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (CE && req.sel && req.enable && !st_q.pready) |=> PREADY)
    else $error("access not answered after one wait");

  COV_IRQ: cover property (@(posedge SYS_CLK) disable iff (!RSTN) $rose(IRQ_REQ));
  COV_ACK: cover property (@(posedge SYS_CLK) disable iff (!RSTN) IRQ_ACK && IRQ_REQ);
  COV_PIN: cover property (@(posedge SYS_CLK) disable iff (!RSTN) pin_edge);
  COV_ERR: cover property (@(posedge SYS_CLK) disable iff (!RSTN) PSLVERR && PREADY);

endmodule // irqfe_bank

// *** test/irqfe_core_model.sv ***
/*
  Model of the processor core and the peripheral event sources.
  Assumes the bank's clock and reset; every output changes after a rising edge.
*/
`timescale 1ns/1ps
module irqfe_core_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [13:0] evt_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  input wire logic irq_req,
  input wire logic [3:0] irq_src,
  output logic [13:0] src_evt,
  output logic irq_ack,
  output logic [3:0] irq_ack_src
);
  logic [13:0] evt_q; // Last request, for step detection
  logic [3:0] cnt_q; // Service latency so far
  logic busy_q; // One acknowledge for each request episode
  // A rising step on an evt_req bit gives a one-cycle event pulse; a pending request is
  // taken after ack_dly cycles, so prompt and slow service are both possible
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_q <= 14'h0000;
      src_evt <= 14'h0000;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      irq_ack <= 1'b0;
      irq_ack_src <= 4'h0;
    end else begin
      evt_q <= evt_req;
      src_evt <= evt_req & ~evt_q;
      irq_ack <= 1'b0;
      // Index means nothing outside an acknowledge, so it never holds still
      irq_ack_src <= ~irq_ack_src;
      if (!irq_req) begin
        cnt_q <= 4'h0;
        busy_q <= 1'b0;
      end else if (ack_en && !busy_q) begin
        if (cnt_q >= ack_dly) begin
          irq_ack <= 1'b1;
          irq_ack_src <= irq_src;
          busy_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // irqfe_core_model

// *** test/tb_top.sv ***
/*
  Self-checking bench for the interrupt flag and enable bank: APB master,
  register table, per-source events, pin edges, service and reset.
  Assumes the design package, bank and core model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } irqfe_row_t;
  logic sys_clk, rstn, ce, psel, penable, pwrite, pready, pslverr, int_pin, er;
  logic irq_ack, irq_req, wake_req, ack_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] src_evt, evt_req;
  logic [3:0] irq_ack_src, irq_src, ack_dly;
  logic [7:0] ofs [5]; // Register offsets in table order
  irqfe_row_t rows [12];
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  irqfe_bank dut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INT_PIN(int_pin), .SRC_EVT(src_evt),
    .IRQ_ACK(irq_ack), .IRQ_ACK_SRC(irq_ack_src), .IRQ_REQ(irq_req),
    .IRQ_SRC(irq_src), .WAKE_REQ(wake_req));

  irqfe_core_model core (
    .clk(sys_clk), .rstn(rstn), .evt_req(evt_req), .ack_en(ack_en),
    .ack_dly(ack_dly), .irq_req(irq_req), .irq_src(irq_src), .src_evt(src_evt),
    .irq_ack(irq_ack), .irq_ack_src(irq_ack_src));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Whole run needs about 760 cycles; a hang ends the run as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'd2, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next setup never lands in this time step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk($sformatf("prdata at %h", a), e, rd);
    chk("pslverr", ee, er);
  endtask

  // Event step to the sources; flag, then outputs, settle before return
  task automatic fire(input logic [13:0] m);
    evt_req <= m;
    tick(1);
    evt_req <= 14'h0000;
    tick(3);
  endtask

  task automatic reset_check();
    int k;
    for (k = 0; k < 5; k++) begin
      rdc(ofs[k], 32'h0, 1'b0);
    end
    chk("wake_req", 1'b0, wake_req);
  endtask

  initial begin
    int i;
    int b;
    logic [7:0] a;
    rstn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    int_pin = 1'b0;
    evt_req = 14'h0000;
    ack_en = 1'b0;
    ack_dly = 4'h0;
    ofs = '{irqfe_pkg::OFS_EDGE_SEL, irqfe_pkg::OFS_CTRL_ZERO,
      irqfe_pkg::OFS_CTRL_ONE, irqfe_pkg::OFS_CTRL_TWO, irqfe_pkg::OFS_CTRL_THREE};
    // Write value, read-back value, error expected
    rows = '{'{ofs[0], 32'hff, 32'h03, 1'b0}, '{ofs[0], 32'h0, 32'h0, 1'b0},
      '{ofs[1], 32'hfe, 32'h7e, 1'b0}, '{ofs[1], 32'h0, 32'h0, 1'b0},
      '{ofs[2], 32'ha5, 32'ha5, 1'b0}, '{ofs[2], 32'h1234565a, 32'h5a, 1'b0},
      '{ofs[3], 32'hc3, 32'hc3, 1'b0}, '{ofs[3], 32'h0, 32'h0, 1'b0},
      '{ofs[4], 32'h3c, 32'h3c, 1'b0}, '{ofs[4], 32'h0, 32'h0, 1'b0},
      '{8'h14, 32'hff, 32'h0, 1'b1}, '{ofs[2], 32'h0, 32'h0, 1'b0}};
    tick(3);
    rstn <= 1'b1;
    reset_check();
    for (i = 0; i < 12; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      chk("pslverr", rows[i].err, er);
      rdc(rows[i].addr, rows[i].exp, rows[i].err);
    end
    // Sources 1 to 14: flag alone, then its own enable plus the global enable
    for (i = 1; i < 15; i++) begin
      a = ofs[(i < 3) ? 1 : (i < 7) ? 2 : (i < 11) ? 3 : 4];
      b = (i < 3) ? i + 4 : (i < 7) ? i + 1 : (i < 11) ? i - 3 : i - 7;
      fire(14'h1 << (i - 1));
      chk("wake_req", 1'b1, wake_req);
      chk("irq_req", 1'b0, irq_req);
      rdc(a, 32'h1 << b, 1'b0);
      wr(a, (32'h1 << b) | (32'h1 << (b - ((i < 3) ? 3 : 4))) | (i < 3));
      if (i > 2) wr(ofs[1], 32'h1);
      tick(3);
      chk("irq_req", 1'b1, irq_req);
      chk("irq_src", i, irq_src);
      wr(a, 32'h0);
      wr(ofs[1], 32'h0);
      tick(3);
      chk("wake_req", 1'b0, wake_req);
    end
    // Pin trigger in every edge mode, rising then falling
    for (i = 0; i < 4; i++) begin
      wr(ofs[0], i);
      int_pin <= 1'b1;
      tick(8);
      rdc(ofs[1], i[0] ? 32'h10 : 32'h0, 1'b0);
      wr(ofs[1], 32'h0);
      int_pin <= 1'b0;
      tick(8);
      rdc(ofs[1], i[1] ? 32'h10 : 32'h0, 1'b0);
      wr(ofs[1], 32'h0);
    end
    // Two sources at once, slow service, then a request while blocked
    wr(ofs[1], 32'h0d);
    fire(14'h3);
    chk("irq_req", 1'b1, irq_req);
    chk("irq_src", 1, irq_src);
    ack_dly <= 4'h3;
    ack_en <= 1'b1;
    tick(10);
    ack_en <= 1'b0;
    chk("irq_req", 1'b0, irq_req);
    rdc(ofs[1], 32'h4c, 1'b0);
    fire(14'h1);
    chk("irq_req", 1'b0, irq_req);
    rdc(ofs[1], 32'h6c, 1'b0);
    wr(ofs[1], 32'h6d);
    tick(3);
    chk("irq_req", 1'b1, irq_req);
    chk("irq_src", 1, irq_src);
    // Prompt service this time
    ack_dly <= 4'h0;
    ack_en <= 1'b1;
    tick(6);
    ack_en <= 1'b0;
    chk("irq_req", 1'b0, irq_req);
    rdc(ofs[1], 32'h4c, 1'b0);
    // Reset again in mid-run with state present
    wr(ofs[4], 32'hff);
    rstn <= 1'b0;
    tick(3);
    rstn <= 1'b1;
    reset_check();
    // Clock enable low: an event pulse must leave no trace
    ce <= 1'b0;
    fire(14'h1);
    ce <= 1'b1;
    tick(2);
    chk("wake_req", 1'b0, wake_req);
    rdc(ofs[1], 32'h0, 1'b0);
    finish_test();
  end
endmodule // tb_top
